// ### logic/ssp_defs.svh
// constants for the synchronous serial port: register map, fields, timing
// assumes inclusion by the package, the top module and the bench only
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// register frame on the 16-bit peripheral bus
`define SSP_BASE 16'h7040
`define SSP_NREG 16'h0009
`define SSP_CCR 4'h0
`define SSP_CTL 4'h1
`define SSP_STS 4'h2
`define SSP_RSV 4'h3
`define SSP_BRR 4'h4
`define SSP_RXH 4'h5
`define SSP_RXL 4'h6
`define SSP_TXH 4'h7
`define SSP_TXL 4'h8
`define SSP_NONE 4'hf

// field positions
`define SSP_CCR_POL 6
`define SSP_CCR_EN 7
`define SSP_CTL_IRQ 0
`define SSP_CTL_TALK 1
`define SSP_CTL_MST 2
`define SSP_CTL_PHA 3
`define SSP_STS_BUSY 5
`define SSP_STS_DONE 6
`define SSP_STS_OVR 7

// reset values
`define SSP_LEN_RST 4'hf
`define SSP_BRR_RST 7'h7f

// fastest rate: 10 Mbps from a 40 MHz core clock, a divide of four
`define SSP_MAX_BPS 10000000
`define SSP_REF_CLK_HZ 40000000
`define SSP_MIN_DIV (`SSP_REF_CLK_HZ / `SSP_MAX_BPS)

`endif

// ### logic/ssp_pkg.sv
// types shared by the serial port modules
// assumes ssp_defs.svh is on the include path
`include "ssp_defs.svh"
package ssp_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL} ssp_mst_t;

    typedef struct packed {
        logic [3:0] len_m1;
        logic pol;
        logic en;
        logic irq_en;
        logic talk;
        logic master;
        logic pha;
    } ssp_cfg_t;

    typedef struct packed {
        ssp_mst_t st;
        logic [6:0] div;
        logic [4:0] edges;
        logic sclk;
        logic [15:0] tx_sr;
        logic [15:0] rx_sr;
        ssp_cfg_t cfg;
        logic [6:0] baud;
        logic [15:0] txw;
        logic [15:0] rxb;
        logic done;
        logic ovr;
        logic [15:0] rdata;
        logic tgl_seen;
    } ssp_st_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic [15:0] sr;
        logic [15:0] word;
        logic tgl;
    } ssp_slv_st_t;

    // keeps the low len_m1+1 bits of a received word
    function automatic logic [15:0] ssp_mask(input logic [3:0] len_m1);
        ssp_mask = 16'hffff >> (4'hf - len_m1);
    endfunction : ssp_mask
endpackage : ssp_pkg

// ### logic/ssp_sync.sv
// two-flop synchroniser, also used as the reset release stage
// assumes the consumer reads only q_out
`timescale 1ns/1ps
module ssp_sync #(
    parameter int W = 1
) (
    input wire logic clk_in, // destination clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic [W-1:0] d_in, // foreign-domain level
    output logic [W-1:0] q_out // synchronised level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssp_sync_st_t;

    ssp_sync_st_t s_r;
    ssp_sync_st_t s_nxt;

    // first stage feeds only the second
    always_comb begin
        s_nxt.s1 = d_in;
        s_nxt.s2 = s_r.s1;
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.s2;
endmodule : ssp_sync

// ### logic/ssp_slave_shift.sv
// slave shifter clocked by the sampling edge of the external serial clock
// assumes len_m1_in and tx_word_in stay still while selected
`timescale 1ns/1ps
module ssp_slave_shift (
    input wire logic link_clk_in, // serial clock, turned so sampling is rising
    input wire logic rst_n_in, // async reset, active low
    input wire logic sel_n_in, // high: ignore clock edges
    input wire logic mosi_in, // data from the master
    input wire logic [3:0] len_m1_in, // word length minus one
    input wire logic [15:0] tx_word_in, // word to send
    output logic miso_out, // current bit toward the master
    output logic [15:0] word_out, // last received word
    output logic done_tgl_out // toggles once per word
);
    ssp_pkg::ssp_slv_st_t s_r;
    ssp_pkg::ssp_slv_st_t s_nxt;

    // shift in on each sampling edge, wrap the count at the word length
    always_comb begin
        s_nxt = s_r;
        if (!sel_n_in) begin
            s_nxt.sr = {s_r.sr[14:0], mosi_in};
            if (s_r.cnt == len_m1_in) begin
                s_nxt.cnt = 4'h0;
                s_nxt.word = {s_r.sr[14:0], mosi_in} & ssp_pkg::ssp_mask(len_m1_in);
                s_nxt.tgl = ~s_r.tgl;
            end else begin
                s_nxt.cnt = s_r.cnt + 4'h1;
            end
        end
    end

    // state register in the link domain
    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // msb first: the bit index counts down from the top of the word
    assign miso_out = tx_word_in[len_m1_in - s_r.cnt];
    assign word_out = s_r.word;
    assign done_tgl_out = s_r.tgl;

    // count never passes the programmed length
    chk_slave_count: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        s_r.cnt <= len_m1_in || $changed(len_m1_in))
        else $error("slave bit count beyond word length");
endmodule : ssp_slave_shift

// ### logic/ssp_top.sv
// synchronous serial port: register frame, master engine, slave link side
// assumes a 16-bit peripheral bus on sys_clk_in and four pins with enables
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_top (
    input wire logic sys_clk_in, // core clock
    input wire logic nrst_in, // async reset, active low
    input wire logic [15:0] addr_in, // peripheral address
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [15:0] wdata_in, // write data
    output logic [15:0] rdata_out, // read data, one cycle after rd_in
    output logic irq_req_out, // word complete and enabled
    input wire logic serial_clock_pin_in, // clock pin level
    output logic serial_clock_pin_out, // clock pin drive
    output logic serial_clock_pin_oe_out, // clock pin enable
    input wire logic slave_in_master_out_in, // mosi pin level
    output logic slave_in_master_out_out, // mosi drive
    output logic slave_in_master_out_oe_out, // mosi enable
    input wire logic slave_out_master_in_in, // miso pin level
    output logic slave_out_master_in_out, // miso drive
    output logic slave_out_master_in_oe_out, // miso enable
    input wire logic slave_transmit_enable_n_in, // select pin level
    output logic slave_transmit_enable_n_out, // select drive
    output logic slave_transmit_enable_n_oe_out // select enable
);
    ssp_pkg::ssp_st_t s_r;
    ssp_pkg::ssp_st_t s_nxt;
    logic rst_n;
    logic slv_tgl;
    logic slv_tgl_s;
    logic miso_s;
    logic slv_miso;
    logic [15:0] slv_word;
    logic samp_rise;
    logic link_clk;
    logic slv_sel_n;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    logic [6:0] eff_div;
    logic [7:0] period;
    logic [6:0] half_a;
    logic [6:0] half_b;
    logic start;
    logic finish;
    logic slave_evt;
    logic new_lvl;

    // maps a bus address to a register index, none outside the frame
    function automatic logic [3:0] reg_index(input logic [15:0] a);
        logic [15:0] off;
        off = a - `SSP_BASE;
        if (a >= `SSP_BASE && off < `SSP_NREG) begin
            reg_index = off[3:0];
        end else begin
            reg_index = `SSP_NONE;
        end
    endfunction : reg_index

    // reset release through two flops
    ssp_sync #(.W(1)) u_rst_sync (
        .clk_in(sys_clk_in),
        .rst_n_in(nrst_in),
        .d_in(1'b1),
        .q_out(rst_n)
    );

    // slave word toggle and master input pin into the core domain
    ssp_sync #(.W(2)) u_in_sync (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .d_in({slv_tgl, slave_out_master_in_in}),
        .q_out({slv_tgl_s, miso_s})
    );

    // sampling edge rises when polarity equals phase
    assign samp_rise = ~(s_r.cfg.pol ^ s_r.cfg.pha);
    assign link_clk = serial_clock_pin_in ^ ~samp_rise;
    assign slv_sel_n = slave_transmit_enable_n_in | s_r.cfg.master | ~s_r.cfg.en;

    ssp_slave_shift u_slave (
        .link_clk_in(link_clk),
        .rst_n_in(rst_n),
        .sel_n_in(slv_sel_n),
        .mosi_in(slave_in_master_out_in),
        .len_m1_in(s_r.cfg.len_m1),
        .tx_word_in(s_r.txw),
        .miso_out(slv_miso),
        .word_out(slv_word),
        .done_tgl_out(slv_tgl)
    );

    // address decode and half periods of the serial clock
    assign wr_idx = reg_index(addr_in);
    assign rd_idx = reg_index(addr_in);
    assign eff_div = (s_r.baud < 7'(`SSP_MIN_DIV - 1)) ? 7'(`SSP_MIN_DIV - 1) : s_r.baud;
    assign period = {1'b0, eff_div} + 8'h01;
    assign half_a = period[7:1];
    assign half_b = 7'(period - {1'b0, half_a});
    assign start = wr_in && wr_idx == `SSP_TXL && s_r.st == ssp_pkg::ST_IDLE &&
                   s_r.cfg.master && s_r.cfg.en;
    assign finish = s_r.st == ssp_pkg::ST_TAIL && s_r.div == 7'h00;
    assign slave_evt = slv_tgl_s ^ s_r.tgl_seen;
    assign new_lvl = ~s_r.sclk;

    // next state: bus access, master engine, completion flags
    always_comb begin
        s_nxt = s_r;
        s_nxt.tgl_seen = slv_tgl_s;
        // register writes use the low byte only
        if (wr_in) begin
            case (wr_idx)
                `SSP_CCR: begin
                    s_nxt.cfg.len_m1 = wdata_in[3:0];
                    s_nxt.cfg.pol = wdata_in[`SSP_CCR_POL];
                    s_nxt.cfg.en = wdata_in[`SSP_CCR_EN];
                end
                `SSP_CTL: begin
                    s_nxt.cfg.irq_en = wdata_in[`SSP_CTL_IRQ];
                    s_nxt.cfg.talk = wdata_in[`SSP_CTL_TALK];
                    s_nxt.cfg.master = wdata_in[`SSP_CTL_MST];
                    s_nxt.cfg.pha = wdata_in[`SSP_CTL_PHA];
                end
                `SSP_STS: begin
                    if (wdata_in[`SSP_STS_OVR]) begin
                        s_nxt.ovr = 1'b0;
                    end
                end
                `SSP_BRR: s_nxt.baud = wdata_in[6:0];
                `SSP_TXH: begin
                    if (s_r.st == ssp_pkg::ST_IDLE) begin
                        s_nxt.txw[15:8] = wdata_in[7:0];
                    end
                end
                `SSP_TXL: begin
                    if (s_r.st == ssp_pkg::ST_IDLE) begin
                        s_nxt.txw[7:0] = wdata_in[7:0];
                    end
                end
                default: s_nxt.baud = s_r.baud;
            endcase
        end
        // registered read data, upper byte zero
        s_nxt.rdata = 16'h0000;
        if (rd_in) begin
            case (rd_idx)
                `SSP_CCR: s_nxt.rdata[7:0] = {s_r.cfg.en, s_r.cfg.pol, 2'h0, s_r.cfg.len_m1};
                `SSP_CTL: s_nxt.rdata[7:0] = {4'h0, s_r.cfg.pha, s_r.cfg.master,
                                              s_r.cfg.talk, s_r.cfg.irq_en};
                `SSP_STS: s_nxt.rdata[7:0] = {s_r.ovr, s_r.done,
                                              s_r.st != ssp_pkg::ST_IDLE, 5'h00};
                `SSP_BRR: s_nxt.rdata[7:0] = {1'b0, s_r.baud};
                `SSP_RXH: s_nxt.rdata[7:0] = s_r.rxb[15:8];
                `SSP_RXL: s_nxt.rdata[7:0] = s_r.rxb[7:0];
                `SSP_TXH: s_nxt.rdata[7:0] = s_r.txw[15:8];
                `SSP_TXL: s_nxt.rdata[7:0] = s_r.txw[7:0];
                default: s_nxt.rdata = 16'h0000;
            endcase
            if (rd_idx == `SSP_RXL) begin
                s_nxt.done = 1'b0;
            end
        end
        // master engine
        case (s_r.st)
            ssp_pkg::ST_IDLE: begin
                s_nxt.sclk = s_r.cfg.pol;
                if (start) begin
                    s_nxt.st = ssp_pkg::ST_RUN;
                    s_nxt.edges = 5'h00;
                    s_nxt.div = half_a - 7'h01;
                    s_nxt.tx_sr = {s_r.txw[15:8], wdata_in[7:0]} << (4'hf - s_r.cfg.len_m1);
                end
            end
            ssp_pkg::ST_RUN: begin
                if (s_r.div == 7'h00) begin
                    s_nxt.sclk = new_lvl;
                    if (new_lvl == samp_rise) begin
                        s_nxt.rx_sr = {s_r.rx_sr[14:0], miso_s};
                    end else if (s_r.edges != 5'h00) begin
                        s_nxt.tx_sr = {s_r.tx_sr[14:0], 1'b0};
                    end
                    s_nxt.edges = s_r.edges + 5'h01;
                    s_nxt.div = (s_r.edges[0] ? half_a : half_b) - 7'h01;
                    if (s_r.edges == {s_r.cfg.len_m1, 1'b1}) begin
                        s_nxt.st = ssp_pkg::ST_TAIL;
                        s_nxt.div = half_a - 7'h01;
                    end
                end else begin
                    s_nxt.div = s_r.div - 7'h01;
                end
            end
            ssp_pkg::ST_TAIL: begin
                if (finish) begin
                    s_nxt.st = ssp_pkg::ST_IDLE;
                end else begin
                    s_nxt.div = s_r.div - 7'h01;
                end
            end
            default: s_nxt.st = ssp_pkg::ST_IDLE;
        endcase
        // completion sets the flags after any clear, so the set wins
        if (finish || slave_evt) begin
            if (s_r.done) begin
                s_nxt.ovr = 1'b1;
            end
            s_nxt.done = 1'b1;
            s_nxt.rxb = finish ? (s_r.rx_sr & ssp_pkg::ssp_mask(s_r.cfg.len_m1)) : slv_word;
        end
    end

    // state register
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= ssp_pkg::ST_IDLE;
            s_r.cfg.len_m1 <= `SSP_LEN_RST;
            s_r.baud <= `SSP_BRR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // pins: every enable drops while the port is off
    assign serial_clock_pin_out = s_r.sclk;
    assign serial_clock_pin_oe_out = s_r.cfg.en & s_r.cfg.master;
    assign slave_in_master_out_out = s_r.tx_sr[15];
    assign slave_in_master_out_oe_out = s_r.cfg.en & s_r.cfg.master & s_r.cfg.talk;
    assign slave_out_master_in_out = slv_miso;
    assign slave_out_master_in_oe_out = ~slv_sel_n & s_r.cfg.talk;
    assign slave_transmit_enable_n_out = s_r.st == ssp_pkg::ST_IDLE;
    assign slave_transmit_enable_n_oe_out = s_r.cfg.en & s_r.cfg.master;
    assign rdata_out = s_r.rdata;
    assign irq_req_out = s_r.done & s_r.cfg.irq_en;

    chk_read_upper: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $past(rd_in) |-> rdata_out[15:8] == 8'h00)
        else $error("upper read byte not zero");

    chk_half_period: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (s_r.st == ssp_pkg::ST_RUN && $changed(s_r.sclk)) |=> $stable(s_r.sclk))
        else $error("serial clock half period below two cycles");

    chk_idle_level: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (s_r.st == ssp_pkg::ST_IDLE && $stable(s_r.cfg.pol)) |=> s_r.sclk == $past(s_r.cfg.pol))
        else $error("idle clock level differs from polarity");

    chk_start_run: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        start |=> s_r.st == ssp_pkg::ST_RUN && !slave_transmit_enable_n_out && s_r.edges == 5'h00)
        else $error("accepted start did not begin a word");

    chk_launch_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (s_r.st == ssp_pkg::ST_RUN && $changed(s_r.sclk) && s_r.sclk == samp_rise) |->
        $stable(s_r.tx_sr))
        else $error("data launched on a sampling edge");

    chk_tx_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !s_r.cfg.talk |-> !slave_in_master_out_oe_out && !slave_out_master_in_oe_out)
        else $error("data pin driven with transmit off");

    chk_pin_release: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !s_r.cfg.en |-> !(serial_clock_pin_oe_out | slave_in_master_out_oe_out |
        slave_out_master_in_oe_out | slave_transmit_enable_n_oe_out))
        else $error("pin driven while port off");

    chk_done_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        finish |=> s_r.done && s_r.st == ssp_pkg::ST_IDLE && s_r.sclk == s_r.cfg.pol)
        else $error("word end did not raise done");

    chk_edge_count: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $rose(s_r.st == ssp_pkg::ST_TAIL) |-> s_r.edges == {s_r.cfg.len_m1, 1'b0} + 5'h02)
        else $error("word ended with wrong edge count");

    chk_slave_float: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        slave_transmit_enable_n_in |-> !slave_out_master_in_oe_out)
        else $error("deselected slave drives its output");
endmodule : ssp_top

// ### dv/ssp_peer.sv
// partner model: external serial device, slave to a master port or
// master with a 15 ns link clock toward a slave port
// assumes the bench resolves each pin from the port's enables
`timescale 1ns/1ps
module ssp_peer (
    input wire logic sclk_in, // clock line
    input wire logic mosi_in, // master-out line
    input wire logic miso_in, // master-in line
    input wire logic sel_n_in, // select line
    input wire logic pol_in, // idle clock level
    input wire logic pha_in, // phase delay
    input wire logic [4:0] len_in, // word length
    input wire logic [15:0] tx_in, // word sent as slave
    output logic sclk_out, // still outside frames
    output logic mosi_out, // master-out level
    output logic miso_out, // master-in level
    output logic sel_n_out // pulled up when released
);
    logic mst = 1'b0;
    logic sel = 1'b0;
    logic clk_r = 1'b0;
    logic [15:0] sr = 16'h0000;
    logic [15:0] rx = 16'h0000;
    int edges = 0;
    realtime t1 = 0.0;
    realtime t3 = 0.0;

    // released data lines show the inverse of the last bit
    assign sclk_out = clk_r;
    assign mosi_out = mst ? sr[15] : ~sr[15];
    assign miso_out = (!mst && sel_n_in === 1'b0) ? sr[15] : ~sr[15];
    assign sel_n_out = ~(mst & sel);

    // slave role: load the word msb-aligned when selected
    always @(negedge sel_n_in) begin
        if (!mst) begin
            sr = tx_in << (16 - len_in);
            edges = 0;
        end
    end

    // slave role: sample on one edge, shift on the other except the first
    always @(sclk_in) begin
        if (!mst && sel_n_in === 1'b0) begin
            edges++;
            if (edges == 1) t1 = $realtime;
            if (edges == 3) t3 = $realtime;
            if (sclk_in == (pol_in ~^ pha_in)) rx = {rx[14:0], mosi_in};
            else if (edges != 1) sr = sr << 1;
        end
    end

    // master role: one frame, miso read just before each sampling edge
    task automatic xfer(input logic [15:0] w, input logic [4:0] n, input logic selected);
        int k;
        mst = 1'b1;
        clk_r = pol_in;
        sr = w << (16 - n);
        #40;
        sel = selected;
        #40;
        for (k = 1; k <= 2 * n; k++) begin
            if ((~clk_r) == (pol_in ~^ pha_in)) begin
                rx = {rx[14:0], miso_in};
                clk_r = ~clk_r;
            end else begin
                clk_r = ~clk_r;
                if (k != 1) sr = sr << 1;
            end
            #7.5;
        end
        #40;
        sel = 1'b0;
        #40;
        mst = 1'b0;
    endtask : xfer
endmodule : ssp_peer

// ### dv/tb.sv
// bench for the serial port: register tasks, master and slave frames
// assumes ssp_defs.svh on the include path and the peer model beside it
`timescale 1ns/1ps
`include "ssp_defs.svh"
module tb;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] wdata_in = 16'h0000;
    logic [15:0] rdata_out;
    logic irq_req_out;
    logic ck_o, ck_oe, mo_o, mo_oe, mi_o, mi_oe, se_o, se_oe;
    logic p_ck, p_mo, p_mi, p_se;
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic [4:0] len = 5'h10;
    logic [15:0] ptx = 16'h0000;
    int err_total = 0;
    int cmp_count = 0;

    // pin levels: the port wins while enabled, else the peer's level
    wire ck_w = ck_oe ? ck_o : p_ck;
    wire mo_w = mo_oe ? mo_o : p_mo;
    wire mi_w = mi_oe ? mi_o : p_mi;
    wire se_w = se_oe ? se_o : p_se;

    always #50 sys_clk_in = ~sys_clk_in;

    ssp_top uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .irq_req_out(irq_req_out), .serial_clock_pin_in(ck_w),
        .serial_clock_pin_out(ck_o), .serial_clock_pin_oe_out(ck_oe),
        .slave_in_master_out_in(mo_w), .slave_in_master_out_out(mo_o),
        .slave_in_master_out_oe_out(mo_oe), .slave_out_master_in_in(mi_w),
        .slave_out_master_in_out(mi_o), .slave_out_master_in_oe_out(mi_oe),
        .slave_transmit_enable_n_in(se_w), .slave_transmit_enable_n_out(se_o),
        .slave_transmit_enable_n_oe_out(se_oe));

    ssp_peer peer (.sclk_in(ck_w), .mosi_in(mo_w), .miso_in(mi_w), .sel_n_in(se_w),
        .pol_in(pol), .pha_in(pha), .len_in(len), .tx_in(ptx), .sclk_out(p_ck),
        .mosi_out(p_mo), .miso_out(p_mi), .sel_n_out(p_se));

    // compare and report
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // register write and read, driven at the falling edge
    task automatic wr(input logic [3:0] idx, input logic [15:0] d);
        @(negedge sys_clk_in);
        addr_in = `SSP_BASE + {12'h000, idx};
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge sys_clk_in);
        wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] idx, output logic [15:0] v);
        @(negedge sys_clk_in);
        addr_in = `SSP_BASE + {12'h000, idx};
        rd_in = 1'b1;
        @(negedge sys_clk_in);
        rd_in = 1'b0;
        v = rdata_out;
    endtask : rd

    // poll the done flag under a bound
    task automatic wait_done;
        logic [15:0] v;
        int i;
        v = 16'h0000;
        for (i = 0; i < 3000 && v[6] !== 1'b1; i++) rd(`SSP_STS, v);
        check("done", v & 16'h0040, 16'h0040);
    endtask : wait_done

    // reset values, byte lanes, reserved and unmapped places, released pins
    task automatic t_regs;
        logic [15:0] v;
        check("pins", {12'h000, ck_oe, mo_oe, mi_oe, se_oe}, 16'h0000);
        rd(`SSP_CCR, v);
        check("ccr", v, 16'h000f);
        rd(`SSP_BRR, v);
        check("brr", v, 16'h007f);
        wr(`SSP_BRR, 16'hff05);
        rd(`SSP_BRR, v);
        check("brr low", v, 16'h0005);
        rd(`SSP_RSV, v);
        check("reserved", v, 16'h0000);
        rd(4'h9, v);
        check("unmapped", v, 16'h0000);
        $display("t_regs done");
    endtask : t_regs

    // one master word in a given scheme, rate and transmit setting
    task automatic t_master(input logic p, input logic h, input logic [4:0] n,
        input logic [7:0] br, input logic [15:0] txw, input logic [15:0] pw, input logic talk);
        logic [15:0] v;
        logic [15:0] lo;
        logic [15:0] m;
        m = 16'hffff >> (5'h10 - n);
        pol = p;
        pha = h;
        len = n;
        ptx = pw;
        wr(`SSP_BRR, {8'h00, br});
        wr(`SSP_CTL, {12'h000, h, 1'b1, talk, 1'b1});
        wr(`SSP_CCR, {8'h00, 1'b1, p, 2'b00, 4'(n - 5'h01)});
        wr(`SSP_TXH, {8'h00, txw[15:8]});
        wr(`SSP_TXL, {8'h00, txw[7:0]});
        check("mpins", {12'h000, ck_oe, mo_oe, se_oe, se_o}, {13'h0001, talk, 2'b10});
        rd(`SSP_STS, v);
        check("busy", v, 16'h0020);
        wait_done;
        check("irq", {15'h0000, irq_req_out}, 16'h0001);
        check("edges", 16'(peer.edges), {10'h000, n, 1'b0});
        if (n > 1) check("period", 16'(int'((peer.t3 - peer.t1) / 100.0)),
            (br < 3) ? 16'h0004 : {8'h00, br} + 16'h0001);
        check("idle", {15'h0000, ck_w}, {15'h0000, p});
        if (talk) check("mosi", peer.rx & m, txw & m);
        rd(`SSP_RXH, v);
        rd(`SSP_RXL, lo);
        if (br > 3) check("rx", {v[7:0], lo[7:0]}, pw & m);
        check("irq off", {15'h0000, irq_req_out}, 16'h0000);
        $display("t_master done");
    endtask : t_master

    // two master words with no receive read between: overrun, then its clear
    task automatic t_ovr;
        logic [15:0] v;
        int i;
        wr(`SSP_TXL, 16'h0001);
        wait_done;
        wr(`SSP_TXL, 16'h0001);
        v = 16'h0020;
        for (i = 0; i < 3000 && v[5] !== 1'b0; i++) rd(`SSP_STS, v);
        check("ovr", v & 16'h0080, 16'h0080);
        wr(`SSP_STS, 16'h0080);
        rd(`SSP_STS, v);
        check("ovr clr", v & 16'h0080, 16'h0000);
        rd(`SSP_RXL, v);
        $display("t_ovr done");
    endtask : t_ovr

    // one slave word from the peer, selected or not
    task automatic t_slave(input logic p, input logic h, input logic [4:0] n,
        input logic [15:0] txw, input logic [15:0] pw, input logic sel);
        logic [15:0] v;
        logic [15:0] lo;
        logic [15:0] m;
        m = 16'hffff >> (5'h10 - n);
        pol = p;
        pha = h;
        len = n;
        wr(`SSP_CTL, {12'h000, h, 3'b010});
        wr(`SSP_TXH, {8'h00, txw[15:8]});
        wr(`SSP_TXL, {8'h00, txw[7:0]});
        wr(`SSP_CCR, {8'h00, 1'b1, p, 2'b00, 4'(n - 5'h01)});
        fork
            peer.xfer(pw, n, sel);
            #100 check("miso oe", {15'h0000, mi_oe}, {15'h0000, sel});
        join
        if (sel) begin
            wait_done;
            rd(`SSP_RXH, v);
            rd(`SSP_RXL, lo);
            check("srx", {v[7:0], lo[7:0]}, pw & m);
            check("stx", peer.rx & m, txw & m);
        end else begin
            repeat (8) @(negedge sys_clk_in);
            rd(`SSP_STS, v);
            check("ignored", v & 16'h0040, 16'h0000);
        end
        $display("t_slave done");
    endtask : t_slave

    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence: reset, registers, all schemes as master then as slave
    initial begin
        repeat (20) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        t_regs;
        t_master(1'b0, 1'b0, 5'h10, 8'h07, 16'ha5c3, 16'h3c5a, 1'b1);
        t_master(1'b0, 1'b1, 5'h01, 8'h09, 16'h0001, 16'h0001, 1'b1);
        t_master(1'b1, 1'b0, 5'h07, 8'h7f, 16'h0055, 16'h002a, 1'b1);
        t_master(1'b1, 1'b1, 5'h0c, 8'h08, 16'h0b6d, 16'h0492, 1'b1);
        t_master(1'b0, 1'b0, 5'h08, 8'h05, 16'h00ff, 16'h0096, 1'b0);
        t_master(1'b0, 1'b0, 5'h03, 8'h02, 16'h0005, 16'h0002, 1'b1);
        t_ovr;
        t_slave(1'b0, 1'b0, 5'h08, 16'h00c5, 16'h003a, 1'b0);
        t_slave(1'b0, 1'b0, 5'h08, 16'h00c5, 16'h003a, 1'b1);
        t_slave(1'b0, 1'b1, 5'h10, 16'h9e21, 16'h57b4, 1'b1);
        t_slave(1'b1, 1'b0, 5'h05, 16'h0013, 16'h000c, 1'b1);
        t_slave(1'b1, 1'b1, 5'h0b, 16'h05a6, 16'h0259, 1'b1);
        tally_and_finish;
    end

    // watchdog against a hang
    initial begin
        #2000000;
        err_total++;
        tally_and_finish;
    end
endmodule : tb
